// *** logic/fan_cfg_pkg.sv ***
// constants for the fan pwm ramp and overtemperature configuration block
package fan_cfg_pkg;

    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned CHANNELS      = 3;
    localparam int unsigned ADDR_W        = 10;
    localparam int unsigned DATA_W        = 32;

    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_SLOPE_FIRST  = 8'h5F;
    localparam logic [7:0]  IDX_SLOPE_SECOND = 8'h60;
    localparam logic [7:0]  IDX_SLOPE_THIRD  = 8'h61;
    localparam logic [7:0]  IDX_RAMP_ONE     = 8'h62;
    localparam logic [7:0]  IDX_LOCK         = 8'h40;
    localparam logic [7:0]  IDX_SLOW         = 8'h41;
    localparam logic [7:0]  IDX_STATUS       = 8'h42;
    localparam int unsigned IDX_LSB          = 2;

    localparam logic [7:0]  SLOPE_RESET      = 8'hC4;
    localparam logic [7:0]  RAMP_ONE_RESET   = 8'h00;
    localparam logic [2:0]  SLOW_RESET       = 3'h0;

    // slope_and_pwm_rate fields
    localparam int unsigned RATE_LSB         = 0;
    localparam int unsigned RATE_W           = 3;
    localparam int unsigned OVERTEMP_EN_BIT  = 3;
    localparam int unsigned SLOPE_LSB        = 4;
    localparam int unsigned SLOPE_W          = 4;

    // acoustic_ramp_control_one fields
    localparam int unsigned RAMP_RATE_LSB    = 0;
    localparam int unsigned RAMP_RATE_W      = 3;
    localparam int unsigned RAMP_EN_BIT      = 3;
    localparam int unsigned SYNC_BIT         = 4;
    localparam int unsigned HOLD_LSB         = 5;

    localparam int unsigned LOCK_BIT         = 0;

    // status register fields
    localparam int unsigned ST_OVERTEMP_LSB  = 0;
    localparam int unsigned ST_PIN_DRIVE_BIT = 3;
    localparam int unsigned ST_PROC_HOT_BIT  = 4;
    localparam int unsigned ST_DUTY_LSB      = 8;

    localparam int unsigned TEMP_W           = 10;
    localparam int unsigned TEMP_FRAC_BITS   = 2;
    localparam int unsigned DUTY_W           = 8;
    localparam logic [7:0]  DUTY_FULL        = 8'hFF;
    localparam logic [7:0]  DUTY_OFF         = 8'h00;

    // ramp timing: a 33% to 100% sweep at one count per slot takes 35 s
    localparam longint unsigned RAMP_FULL_TIME_MS = 35000;
    localparam longint unsigned RAMP_SPAN_COUNTS  = 171;
    localparam longint unsigned RAMP_SLOT_CALC    =
        (longint'(CLK_HZ) / 1000 * RAMP_FULL_TIME_MS) / RAMP_SPAN_COUNTS;
    localparam int unsigned SLOW_FACTOR       = 4;
    localparam int unsigned SLOT_W            = 30;

    localparam logic [7:0] RAMP_STEP [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
                                             8'h08, 8'h0C, 8'h18, 8'h30};

    // pwm rate: code 000 is 11.0 Hz, a period of 256 duty steps
    localparam longint unsigned RATE_BASE_TENTHS_HZ = 110;
    localparam longint unsigned PWM_STEPS           = 256;
    localparam longint unsigned RATE_STEP_CALC      =
        (longint'(CLK_HZ) * 10) / (RATE_BASE_TENTHS_HZ * PWM_STEPS);
    localparam int unsigned PRESCALE_W = 24;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : fan_cfg_pkg

// *** logic/pwm_channel.sv ***
// one fan pwm output with selectable rate
`timescale 1ns/10ps
`default_nettype none

module pwm_channel
    import fan_cfg_pkg::*;
#(
    parameter int unsigned RATE_STEP_CYCLES = 32'd71022
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [RATE_W-1:0]    rate_code,
    input  wire logic [DUTY_W-1:0]    duty,
    output logic                      drive
);

    typedef struct packed {
        logic [PRESCALE_W-1:0] prescale;
        logic [DUTY_W-1:0]     phase;
        logic                  drive;
    } pwm_state_type;

    pwm_state_type state_reg;
    pwm_state_type state_next;
    logic [PRESCALE_W-1:0] step_len;

    // higher codes divide the base step by the code plus one; code 000 uses the base step
    assign step_len = PRESCALE_W'(RATE_STEP_CYCLES / (32'(rate_code) + 32'd1));

    always_comb begin
        state_next = state_reg;
        if (state_reg.prescale + PRESCALE_W'(1) >= step_len) begin
            state_next.prescale = '0;
            state_next.phase    = state_reg.phase + DUTY_W'(1);
        end else begin
            state_next.prescale = state_reg.prescale + PRESCALE_W'(1);
        end
        state_next.drive = (duty == DUTY_FULL) || (state_reg.phase < duty);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign drive = state_reg.drive;

endmodule : pwm_channel

`default_nettype wire

// *** logic/fan_pwm_ramp_ctrl.sv ***
// fan pwm ramp and overtemperature pin control
// Operation
// - three low bits pick pwm rate; 000=11Hz
// - enabled: drive pin low at or above limit+0.25C
// - pin stays low until temp <= limit
// - assertion lasts one monitoring cycle minimum
// - disabled: pin input only, never driven
// - upper four bits set auto slope
// - first output ramps toward new duty
// - rate codes give steps 1..48 per slot
// - ramp only while enable bit set
// - sync bit adds second speed input
// - below start: zero or minimum duty
// - lock makes ramp register read-only
// - lock makes slope registers read-only
// - slow bit stretches ramps fourfold
`timescale 1ns/10ps
`default_nettype none

module fan_pwm_ramp_ctrl
    import fan_cfg_pkg::*;
#(
    parameter int unsigned RAMP_SLOT_CYCLES = 32'(RAMP_SLOT_CALC),
    parameter int unsigned RATE_STEP_CYCLES = 32'(RATE_STEP_CALC)
) (
    input  wire logic                                aclk,
    input  wire logic                                aresetn,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0]                   s_axi_awaddr,
    input  wire logic                                s_axi_awvalid,
    output logic                                     s_axi_awready,
    input  wire logic [DATA_W-1:0]                   s_axi_wdata,
    input  wire logic [3:0]                          s_axi_wstrb,
    input  wire logic                                s_axi_wvalid,
    output logic                                     s_axi_wready,
    output logic [1:0]                               s_axi_bresp,
    output logic                                     s_axi_bvalid,
    input  wire logic                                s_axi_bready,
    input  wire logic [ADDR_W-1:0]                   s_axi_araddr,
    input  wire logic                                s_axi_arvalid,
    output logic                                     s_axi_arready,
    output logic [DATA_W-1:0]                        s_axi_rdata,
    output logic [1:0]                               s_axi_rresp,
    output logic                                     s_axi_rvalid,
    input  wire logic                                s_axi_rready,
    // temperature monitor side
    input  wire logic [CHANNELS-1:0][TEMP_W-1:0]     temp_quarter,
    input  wire logic [CHANNELS-1:0][DUTY_W-1:0]     overtemp_limit,
    input  wire logic                                monitor_cycle_done,
    input  wire logic                                auto_mode,
    input  wire logic [CHANNELS-1:0]                 below_start,
    input  wire logic [CHANNELS-1:0][DUTY_W-1:0]     min_duty,
    input  wire logic [CHANNELS-1:0][DUTY_W-1:0]     demand_duty,
    // overtemperature pin, open drain
    input  wire logic                                overtemp_pin_i,
    output logic                                     overtemp_pin_o,
    output logic                                     overtemp_pin_oe,
    // fan and speed measurement side
    output logic                                     fan_drive_first,
    output logic                                     fan_drive_second,
    output logic                                     fan_drive_third,
    output logic [CHANNELS-1:0][SLOPE_W-1:0]         auto_slope_code,
    output logic                                     meas_window_second,
    output logic                                     meas_window_third,
    output logic                                     meas_window_fourth
);

    typedef struct packed {
        // registers
        logic [CHANNELS-1:0][7:0]        slope_and_pwm_rate;
        logic [7:0]                      acoustic_ramp_control_one;
        logic [CHANNELS-1:0]             slow;
        logic                            lock;
        // overtemperature
        logic [CHANNELS-1:0]             overtemp;
        logic                            pin_oe;
        logic                            proc_hot;
        // duty path
        logic [CHANNELS-1:0][DUTY_W-1:0] duty;
        logic [SLOT_W-1:0]               slot_cnt;
        logic [CHANNELS-1:0][SLOPE_W-1:0] slope_out;
        logic [2:0]                      meas_window;
        // bus
        logic                            awready;
        logic                            aw_held;
        logic [7:0]                      aw_idx;
        logic                            wready;
        logic                            w_held;
        logic [7:0]                      w_byte;
        logic                            w_lane;
        logic                            bvalid;
        logic [1:0]                      bresp;
        logic                            arready;
        logic                            rvalid;
        logic [DATA_W-1:0]               rdata;
        logic [1:0]                      rresp;
    } ctrl_state_type;

    ctrl_state_type state_reg;
    ctrl_state_type state_next;

    logic [CHANNELS-1:0]             drive_raw;
    logic [CHANNELS-1:0][DUTY_W-1:0] target;
    logic [SLOT_W-1:0]               slot_len;
    logic                            slot_tick;
    logic [DUTY_W-1:0]               step;

    // reset value of the whole state
    function automatic ctrl_state_type reset_state();
        ctrl_state_type s;
        s = '0;
        for (int i = 0; i < CHANNELS; i++) begin
            s.slope_and_pwm_rate[i] = SLOPE_RESET;
        end
        s.acoustic_ramp_control_one = RAMP_ONE_RESET;
        s.slow     = SLOW_RESET;
        s.awready  = 1'b1;
        s.wready   = 1'b1;
        s.arready  = 1'b1;
        return s;
    endfunction : reset_state

    function automatic logic [DUTY_W-1:0] approach(input logic [DUTY_W-1:0] now,
                                                   input logic [DUTY_W-1:0] goal,
                                                   input logic [DUTY_W-1:0] inc);
        logic [DUTY_W-1:0] r;
        r = now;
        if (now < goal) begin
            r = (goal - now <= inc) ? goal : now + inc;
        end else if (now > goal) begin
            r = (now - goal <= inc) ? goal : now - inc;
        end
        return r;
    endfunction : approach

    // below-start selection and target duty per channel
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            if (auto_mode && below_start[i]) begin
                target[i] = state_reg.acoustic_ramp_control_one[HOLD_LSB + i] ?
                            min_duty[i] : DUTY_OFF;
            end else begin
                target[i] = demand_duty[i];
            end
        end
    end

    assign step = RAMP_STEP[state_reg.acoustic_ramp_control_one[RAMP_RATE_LSB +: RAMP_RATE_W]];
    assign slot_len = state_reg.slow[0] ?
                      SLOT_W'(RAMP_SLOT_CYCLES) * SLOT_W'(SLOW_FACTOR) :
                      SLOT_W'(RAMP_SLOT_CYCLES);
    assign slot_tick = (state_reg.slot_cnt + SLOT_W'(1) >= slot_len);

    always_comb begin
        logic [7:0] idx;
        logic       hit;
        state_next = state_reg;
        idx = 8'h00;
        hit = 1'b0;

        // ramp slot timer
        state_next.slot_cnt = slot_tick ? '0 : state_reg.slot_cnt + SLOT_W'(1);

        // duty update: first output ramps when enabled, others follow at once
        if (state_reg.acoustic_ramp_control_one[RAMP_EN_BIT]) begin
            if (slot_tick) begin
                state_next.duty[0] = approach(state_reg.duty[0], target[0], step);
            end
        end else begin
            state_next.duty[0] = target[0];
        end
        for (int i = 1; i < CHANNELS; i++) begin
            state_next.duty[i] = target[i];
        end

        // slope codes handed to the automatic control loop
        for (int i = 0; i < CHANNELS; i++) begin
            state_next.slope_out[i] =
                state_reg.slope_and_pwm_rate[i][SLOPE_LSB +: SLOPE_W];
        end

        // overtemperature decisions once per monitoring cycle
        for (int i = 0; i < CHANNELS; i++) begin
            if (!state_reg.slope_and_pwm_rate[i][OVERTEMP_EN_BIT]) begin
                state_next.overtemp[i] = 1'b0;
            end else if (monitor_cycle_done) begin
                if (temp_quarter[i] > {overtemp_limit[i], {TEMP_FRAC_BITS{1'b0}}}) begin
                    state_next.overtemp[i] = 1'b1;
                end else begin
                    state_next.overtemp[i] = 1'b0;
                end
            end
        end
        state_next.pin_oe   = |state_next.overtemp;
        state_next.proc_hot = !overtemp_pin_i && !state_reg.pin_oe;

        // speed measurement windows follow the third output; the second window only when synchronised
        state_next.meas_window[0] =
            state_reg.acoustic_ramp_control_one[SYNC_BIT] ? drive_raw[2] : 1'b1;
        state_next.meas_window[1] = drive_raw[2];
        state_next.meas_window[2] = drive_raw[2];

        // write address and data, taken in either order
        if (s_axi_awvalid && state_reg.awready) begin
            state_next.aw_held = 1'b1;
            state_next.awready = 1'b0;
            state_next.aw_idx  = s_axi_awaddr[IDX_LSB +: 8];
        end
        if (s_axi_wvalid && state_reg.wready) begin
            state_next.w_held = 1'b1;
            state_next.wready = 1'b0;
            state_next.w_byte = s_axi_wdata[7:0];
            state_next.w_lane = s_axi_wstrb[0];
        end

        if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
            state_next.aw_held = 1'b0;
            state_next.w_held  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = RESP_OKAY;
            hit = 1'b1;
            case (state_reg.aw_idx)
                IDX_SLOPE_FIRST, IDX_SLOPE_SECOND, IDX_SLOPE_THIRD: begin
                    if (state_reg.w_lane && !state_reg.lock) begin
                        state_next.slope_and_pwm_rate[state_reg.aw_idx - IDX_SLOPE_FIRST] =
                            state_reg.w_byte;
                    end
                end
                IDX_RAMP_ONE: begin
                    if (state_reg.w_lane && !state_reg.lock) begin
                        state_next.acoustic_ramp_control_one = state_reg.w_byte;
                    end
                end
                IDX_SLOW: begin
                    if (state_reg.w_lane && !state_reg.lock) begin
                        state_next.slow = state_reg.w_byte[CHANNELS-1:0];
                    end
                end
                IDX_LOCK: begin
                    if (state_reg.w_lane && state_reg.w_byte[LOCK_BIT]) begin
                        state_next.lock = 1'b1;
                    end
                end
                IDX_STATUS: begin
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
            if (!hit) begin
                state_next.bresp = RESP_SLVERR;
            end
        end
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid  = 1'b0;
            state_next.awready = 1'b1;
            state_next.wready  = 1'b1;
        end

        // read channel
        if (s_axi_arvalid && state_reg.arready) begin
            idx = s_axi_araddr[IDX_LSB +: 8];
            state_next.arready = 1'b0;
            state_next.rvalid  = 1'b1;
            state_next.rdata   = '0;
            state_next.rresp   = RESP_OKAY;
            case (idx)
                IDX_SLOPE_FIRST, IDX_SLOPE_SECOND, IDX_SLOPE_THIRD: begin
                    state_next.rdata[7:0] = state_reg.slope_and_pwm_rate[idx - IDX_SLOPE_FIRST];
                end
                IDX_RAMP_ONE: begin
                    state_next.rdata[7:0] = state_reg.acoustic_ramp_control_one;
                end
                IDX_SLOW: begin
                    state_next.rdata[CHANNELS-1:0] = state_reg.slow;
                end
                IDX_LOCK: begin
                    state_next.rdata[LOCK_BIT] = state_reg.lock;
                end
                IDX_STATUS: begin
                    state_next.rdata[ST_OVERTEMP_LSB +: CHANNELS] = state_reg.overtemp;
                    state_next.rdata[ST_PIN_DRIVE_BIT] = state_reg.pin_oe;
                    state_next.rdata[ST_PROC_HOT_BIT]  = state_reg.proc_hot;
                    state_next.rdata[ST_DUTY_LSB +: DUTY_W] = state_reg.duty[0];
                end
                default: begin
                    state_next.rresp = RESP_SLVERR;
                end
            endcase
        end
        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid  = 1'b0;
            state_next.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= reset_state();
        end else begin
            state_reg <= state_next;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : gen_pwm
            pwm_channel #(
                .RATE_STEP_CYCLES (RATE_STEP_CYCLES)
            ) u_pwm (
                .aclk      (aclk),
                .aresetn   (aresetn),
                .rate_code (state_reg.slope_and_pwm_rate[g][RATE_LSB +: RATE_W]),
                .duty      (state_reg.duty[g]),
                .drive     (drive_raw[g])
            );
        end
    endgenerate

    assign fan_drive_first    = drive_raw[0];
    assign fan_drive_second   = drive_raw[1];
    assign fan_drive_third    = drive_raw[2];
    assign overtemp_pin_o     = 1'b0;
    assign overtemp_pin_oe    = state_reg.pin_oe;
    assign auto_slope_code    = state_reg.slope_out;
    assign meas_window_second = state_reg.meas_window[0];
    assign meas_window_third  = state_reg.meas_window[1];
    assign meas_window_fourth = state_reg.meas_window[2];
    assign s_axi_awready      = state_reg.awready;
    assign s_axi_wready       = state_reg.wready;
    assign s_axi_bvalid       = state_reg.bvalid;
    assign s_axi_bresp        = state_reg.bresp;
    assign s_axi_arready      = state_reg.arready;
    assign s_axi_rvalid       = state_reg.rvalid;
    assign s_axi_rdata        = state_reg.rdata;
    assign s_axi_rresp        = state_reg.rresp;

endmodule : fan_pwm_ramp_ctrl

`default_nettype wire

// *** sim/fan_pwm_ramp_ctrl_assertions.sv ***
// port checks of fan pwm ramp control
`timescale 1ns/10ps
`default_nettype none

module fan_pwm_ramp_ctrl_assertions
    import fan_cfg_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              monitor_cycle_done,
    input wire logic              overtemp_pin_o,
    input wire logic              overtemp_pin_oe,
    input wire logic              meas_window_second,
    input wire logic              meas_window_third,
    input wire logic              meas_window_fourth
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence write_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence

    pin_level_a: assert property (overtemp_pin_oe |-> !overtemp_pin_o)
        else $error("pin high");
    pin_assert_a: assert property ($rose(overtemp_pin_oe) |-> $past(monitor_cycle_done))
        else $error("pin set off pulse");
    pin_hold_a: assert property ($fell(overtemp_pin_oe) |-> $past(monitor_cycle_done)
        || $past(s_axi_bvalid))
        else $error("pin freed early");
    window_pair_a: assert property (meas_window_fourth == meas_window_third)
        else $error("window pair");
    window_sync_a: assert property (meas_window_third |-> meas_window_second)
        else $error("window sync");
    write_latency_a: assert property (write_taken |=> write_answer)
        else $error("write late");
    read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read late");
    slverr_data_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
        |-> s_axi_rdata == 32'h0)
        else $error("error data");
endmodule : fan_pwm_ramp_ctrl_assertions

bind fan_pwm_ramp_ctrl fan_pwm_ramp_ctrl_assertions i_chk (.*);
`default_nettype wire

// *** sim/fan_load.sv ***
// fan load: counts drive-on cycles
`timescale 1ns/10ps
`default_nettype none

module fan_load (
    input  wire logic   aclk,
    input  wire logic   restart,
    input  wire logic   drive,
    output logic [15:0] on_cycles
);
    always_ff @(posedge aclk) begin
        if (restart) begin
            on_cycles <= 16'h0000;
        end else begin
            on_cycles <= on_cycles + {15'h0000, drive};
        end
    end
endmodule : fan_load
`default_nettype wire

// *** sim/fan_pwm_ramp_ctrl_test.sv ***
// bench for fan pwm ramp control
`timescale 1ns/10ps
`default_nettype none

module fan_pwm_ramp_ctrl_test import fan_cfg_pkg::*;;
    localparam int RS = 20;
    localparam int RATE_STEP = 20;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, restart;
    logic monitor_cycle_done, auto_mode, overtemp_pin_o, overtemp_pin_oe;
    logic fan_drive_first, fan_drive_second, fan_drive_third;
    logic meas_window_second, meas_window_third, meas_window_fourth;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, d, d0;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs_w, rs_r;
    logic [CHANNELS-1:0][TEMP_W-1:0] temp_quarter;
    logic [CHANNELS-1:0][DUTY_W-1:0] overtemp_limit, min_duty, demand_duty;
    logic [CHANNELS-1:0][SLOPE_W-1:0] auto_slope_code;
    logic [CHANNELS-1:0] below_start;
    logic [15:0] on_cycles;
    int n_fail, n_tests, cyc;
    int st[8] = '{1, 2, 3, 4, 8, 12, 24, 48};
    wire logic overtemp_pin_i = overtemp_pin_oe ? overtemp_pin_o : 1'b1;

    fan_pwm_ramp_ctrl #(.RAMP_SLOT_CYCLES(RS), .RATE_STEP_CYCLES(RATE_STEP)) i_dut (.*);
    fan_load i_fan (.aclk, .restart, .drive(fan_drive_second), .on_cycles);

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] ix, input logic [7:0] v);
        @(posedge aclk);
        s_axi_awaddr <= {ix, 2'b00};
        s_axi_wdata <= 32'(v);
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        rs_w = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] ix);
        @(posedge aclk);
        s_axi_araddr <= {ix, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        rs_r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic pulse();
        monitor_cycle_done <= 1'b1;
        @(posedge aclk);
        monitor_cycle_done <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask : pulse

    task automatic fan_count();
        restart <= 1'b1;
        @(posedge aclk);
        restart <= 1'b0;
        repeat (256 * RATE_STEP + 1) @(posedge aclk);
    endtask : fan_count

    task automatic ramp(input logic [2:0] k, input int lo, input int hi);
        wr(IDX_RAMP_ONE, 8'h00);
        demand_duty[0] <= 8'h00;
        repeat (2) @(posedge aclk);
        rd(IDX_STATUS);
        chk("duty_unramped", 32'h0, 32'(d[15:8]));
        wr(IDX_RAMP_ONE, {5'b00001, k});
        demand_duty[0] <= 8'hF0;
        rd(IDX_STATUS);
        d0 = d;
        repeat (60) @(posedge aclk);
        rd(IDX_STATUS);
        chk("ramp_step", 32'h1, {31'h0, (d[15:8] - d0[15:8]) inside {[lo:hi]}});
    endtask : ramp

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            results();
        end
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {monitor_cycle_done, auto_mode, restart, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {temp_quarter, overtemp_limit, min_duty, demand_duty, below_start} = '0;
        s_axi_wstrb = 4'hF;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            rd(IDX_SLOPE_FIRST + 8'(i));
            chk("slope_reset", 32'hC4, d);
        end
        rd(IDX_RAMP_ONE);
        chk("ramp_reset", 32'h0, d);
        overtemp_limit[0] <= 8'h32;
        temp_quarter[0] <= 10'h0C8;
        wr(IDX_SLOPE_FIRST, 8'hA8);
        rd(IDX_SLOPE_FIRST);
        chk("slope_rd", 32'hA8, d);
        chk("slope_out", 32'hCCA, 32'(auto_slope_code));
        pulse();
        chk("pin_at_limit", 32'h0, 32'(overtemp_pin_oe));
        temp_quarter[0] <= 10'h0C9;
        pulse();
        chk("pin_above", 32'h1, 32'(overtemp_pin_oe));
        temp_quarter[0] <= 10'h0C8;
        repeat (20) @(posedge aclk);
        chk("pin_held", 32'h1, 32'(overtemp_pin_oe));
        temp_quarter[1] <= 10'h3FF;
        pulse();
        chk("pin_off", 32'h0, 32'(overtemp_pin_oe));
        wr(IDX_SLOPE_SECOND, 8'hC0);
        auto_mode <= 1'b1;
        below_start <= 3'b111;
        min_duty <= {3{8'h30}};
        demand_duty <= {8'h80, 8'hFF, 8'hFF};
        wr(IDX_RAMP_ONE, 8'h40);
        rd(IDX_STATUS);
        chk("duty_zero", 32'h0, 32'(d[15:8]));
        fan_count();
        chk("fan_min", 32'(48 * RATE_STEP), 32'(on_cycles));
        wr(IDX_RAMP_ONE, 8'h20);
        rd(IDX_STATUS);
        chk("duty_min", 32'h30, 32'(d[15:8]));
        fan_count();
        chk("fan_off", 32'h0, 32'(on_cycles));
        auto_mode <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            ramp(3'(k), 2 * st[k], 4 * st[k]);
            repeat ((240 / st[k] + 2) * RS) @(posedge aclk);
            rd(IDX_STATUS);
            chk("ramp_end", 32'hF0, 32'(d[15:8]));
        end
        wr(IDX_SLOW, 8'h01);
        ramp(3'h0, 0, 1);
        wr(IDX_RAMP_ONE, 8'h10);
        repeat (8) @(posedge aclk);
        wr(IDX_LOCK, 8'h01);
        wr(IDX_RAMP_ONE, 8'hEF);
        wr(IDX_SLOPE_FIRST, 8'h00);
        rd(IDX_RAMP_ONE);
        chk("ramp_locked", 32'h10, d);
        rd(IDX_SLOPE_FIRST);
        chk("slope_locked", 32'hA8, d);
        wr(8'hFF, 8'h00);
        chk("wr_unmapped", {30'h0, RESP_SLVERR}, {30'h0, rs_w});
        rd(8'hFF);
        chk("rd_unmapped", {30'h0, RESP_SLVERR}, {30'h0, rs_r});
        results();
    end
endmodule : fan_pwm_ramp_ctrl_test
`default_nettype wire
